// *** eeos_fault_out_ctrl.sv ***
`timescale 1ns/1ps
module eeos_fault_out_ctrl (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Configuration and on-chip events.
  input wire logic single_pin_mode,
  input wire logic fault_active,
  input wire eeos_pkg::eeos_sw_evt_t sw_evt,
  // Voltage detector errors, asynchronous levels.
  input wire logic low_voltage_detector_err,
  input wire logic high_voltage_detector_err,
  // Fault pins: level read back on the pad, and drive.
  input wire logic fault_out_0_i,
  input wire logic fault_out_1_i,
  output eeos_pkg::eeos_pin_drv_t fault_out_0,
  output eeos_pkg::eeos_pin_drv_t fault_out_1,
  // External reset output, active low.
  output logic external_reset_out_n,
  // Separate signalling path to the supervisor.
  output logic init_confirm,
  output logic service_pulse,
  // Status.
  output logic safety_run,
  output logic pin_check_fail,
  output logic safe_state_req
);
  import eeos_pkg::*;

  localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(EXT_RST_CYC - 1);
  localparam logic [CNT_W-1:0] CHK_LAST = CNT_W'(PIN_CHECK_CYC - 1);

  eeos_state_t state_r;
  eeos_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic phase_r;
  logic phase_nxt;
  logic pin0_r;
  logic pin0_nxt;
  logic pin1_r;
  logic pin1_nxt;
  logic ext_rst_n_r;
  logic ext_rst_n_nxt;
  logic confirm_r;
  logic confirm_nxt;
  logic svc_r;
  logic svc_nxt;
  logic chk_fail_r;
  logic chk_fail_nxt;
  logic [3:0] sync_in;
  logic [3:0] sync_q;
  logic rb0;
  logic rb1;
  logic volt_err_s;
  logic rb_ok;

  assign sync_in = {fault_out_1_i, fault_out_0_i, high_voltage_detector_err, low_voltage_detector_err};

  // Pad readback and detector levels come from outside this clock domain.
  eeos_sync3 #(
    .W(4),
    .RST_VAL(4'h0)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(sync_in),
    .sync_out(sync_q)
  );

  assign rb0 = sync_q[2];
  assign rb1 = sync_q[3];
  assign volt_err_s = sync_q[0] | sync_q[1];
  // The unused pin is not checked in single-pin mode.
  assign rb_ok = (rb0 == PIN0_FAIL) && (single_pin_mode || (rb1 == PIN1_FAIL));

  // Sequencer: every step waits for its own completion event, so no step can be skipped.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    chk_fail_nxt = chk_fail_r;
    case (state_r)
      EEOS_POR: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cnt_r == RST_LAST) begin
          cnt_nxt = '0;
          state_nxt = EEOS_SELF_INIT;
        end
      end
      EEOS_SELF_INIT: begin
        if (sw_evt.startup_tests_done) begin
          state_nxt = EEOS_EXT_INIT;
        end
      end
      EEOS_EXT_INIT: begin
        if (sw_evt.ext_init_done) begin
          cnt_nxt = '0;
          state_nxt = EEOS_PIN_CHECK;
        end
      end
      EEOS_PIN_CHECK: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cnt_r == CHK_LAST) begin
          cnt_nxt = '0;
          if (rb_ok) begin
            state_nxt = EEOS_HANDOVER;
          end else begin
            chk_fail_nxt = 1'b1;
            state_nxt = EEOS_FAIL;
          end
        end
      end
      EEOS_HANDOVER: begin
        if (sw_evt.sw_init_ok) begin
          state_nxt = EEOS_RUN;
        end
      end
      EEOS_RUN: begin
        state_nxt = EEOS_RUN;
      end
      EEOS_FAIL: begin
        state_nxt = EEOS_FAIL;
      end
      default: begin
        state_nxt = EEOS_FAIL;
      end
    endcase
    // A supply fault overrides every step and is left only through reset.
    if (volt_err_s) begin
      state_nxt = EEOS_FAIL;
    end
  end

  // Pin drive and the outputs toward the supervisor.
  always_comb begin
    phase_nxt = phase_r;
    svc_nxt = 1'b0;
    confirm_nxt = (state_nxt == EEOS_RUN);
    ext_rst_n_nxt = (state_nxt != EEOS_POR) && !volt_err_s;
    pin0_nxt = PIN0_FAIL;
    pin1_nxt = PIN1_FAIL;
    if (state_r == EEOS_RUN && sw_evt.sw_service) begin
      phase_nxt = ~phase_r;
      svc_nxt = 1'b1;
    end
    // Up to the handover the pins stay in the fail pattern, so a stuck multiplexer reads as failure.
    if ((state_nxt == EEOS_HANDOVER || state_nxt == EEOS_RUN) && !fault_active) begin
      pin0_nxt = single_pin_mode ? 1'b1 : phase_nxt;
      pin1_nxt = phase_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= EEOS_POR;
      cnt_r <= '0;
      chk_fail_r <= 1'b0;
      phase_r <= PHASE_RST;
      svc_r <= 1'b0;
      confirm_r <= 1'b0;
      ext_rst_n_r <= 1'b0;
      pin0_r <= PIN0_FAIL;
      pin1_r <= PIN1_FAIL;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      chk_fail_r <= chk_fail_nxt;
      phase_r <= phase_nxt;
      svc_r <= svc_nxt;
      confirm_r <= confirm_nxt;
      ext_rst_n_r <= ext_rst_n_nxt;
      pin0_r <= pin0_nxt;
      pin1_r <= pin1_nxt;
    end
  end

  // Pin 1 is released in single-pin mode so the board can use it freely.
  assign fault_out_0 = '{o: pin0_r, oe_n: 1'b0};
  assign fault_out_1 = '{o: pin1_r, oe_n: single_pin_mode};
  assign external_reset_out_n = ext_rst_n_r;
  assign init_confirm = confirm_r;
  assign service_pulse = svc_r;
  assign safety_run = (state_r == EEOS_RUN);
  assign pin_check_fail = chk_fail_r;
  // Raw detector levels bypass the synchroniser so the request does not wait for the clock.
  assign safe_state_req = low_voltage_detector_err | high_voltage_detector_err | (state_r == EEOS_FAIL);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_pin_check_end;
    state_r == EEOS_PIN_CHECK && cnt_r == CHK_LAST;
  endsequence

  sequence s_served;
    state_r == EEOS_RUN && sw_evt.sw_service && !volt_err_s;
  endsequence

  AST_RST_WIDTH: assert property (
    (state_r == EEOS_SELF_INIT && $past(state_r) == EEOS_POR) |-> $past(cnt_r) == RST_LAST && !$past(ext_rst_n_r))
    else $error("external reset released before its full width");

  AST_RUN_ORDER: assert property (
    $rose(state_r == EEOS_RUN) |-> $past(state_r) == EEOS_HANDOVER && $past(sw_evt.sw_init_ok))
    else $error("run entered out of order");

  AST_FAIL_UNTIL_HANDOVER: assert property (
    (state_r != EEOS_HANDOVER && state_r != EEOS_RUN) |-> pin0_r == PIN0_FAIL && pin1_r == PIN1_FAIL)
    else $error("fault pin left fail level before handover");

  AST_CHECK_BAD: assert property (
    (s_pin_check_end ##0 !rb_ok && !volt_err_s) |=> state_r == EEOS_FAIL && chk_fail_r && safe_state_req)
    else $error("failed pin readback not flagged");

  AST_CHECK_GOOD: assert property (
    (s_pin_check_end ##0 rb_ok && !volt_err_s) |=> state_r == EEOS_HANDOVER && !chk_fail_r)
    else $error("good pin readback not accepted");

  AST_SERVICE_TOGGLE: assert property (
    (s_served ##0 !fault_active && !single_pin_mode) |=>
      phase_r != $past(phase_r) && pin0_r == phase_r && pin1_r == phase_r && service_pulse)
    else $error("service did not toggle the fault pins");

  AST_VOLT_SAFE: assert property (
    volt_err_s |=> state_r == EEOS_FAIL && !external_reset_out_n && safe_state_req)
    else $error("voltage error did not force safe state");

  AST_CONFIRM: assert property (
    $rose(init_confirm) |-> $past(sw_evt.sw_init_ok) && safety_run ##1 init_confirm || state_r == EEOS_FAIL)
    else $error("init confirm without software acknowledgement");

endmodule

// *** eeos_pkg.sv ***
package eeos_pkg;

  // Clock period of clk_sys in nanoseconds (10 MHz).
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Least width of the reset pulse sent to external devices after power-on.
  localparam int unsigned EXT_RST_NS = 10000;
  localparam int unsigned EXT_RST_CYC = (EXT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Least time the fail pattern stands on the pins before it is read back.
  localparam int unsigned PIN_CHECK_NS = 2000;
  localparam int unsigned PIN_CHECK_CYC = (PIN_CHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of the shared sequencing counter.
  localparam int unsigned CNT_W = 8;

  // Pin levels after reset and in the fail pattern.
  localparam logic PIN0_FAIL = 1'b0;
  localparam logic PIN1_FAIL = 1'b1;
  localparam logic PHASE_RST = 1'b1;

  // Start-up and run sequence of the error output controller.
  typedef enum logic [2:0] {
    EEOS_POR       = 3'b000,
    EEOS_SELF_INIT = 3'b001,
    EEOS_EXT_INIT  = 3'b010,
    EEOS_PIN_CHECK = 3'b011,
    EEOS_HANDOVER  = 3'b100,
    EEOS_RUN       = 3'b101,
    EEOS_FAIL      = 3'b110
  } eeos_state_t;

  // Drive of one two-way pin; oe_n low while this side drives it.
  typedef struct packed {
    logic o;
    logic oe_n;
  } eeos_pin_drv_t;

  // Software-side events of the start-up and run sequence, each a one-cycle pulse.
  typedef struct packed {
    logic startup_tests_done;
    logic ext_init_done;
    logic sw_init_ok;
    logic sw_service;
  } eeos_sw_evt_t;

endpackage

// *** eeos_sync3.sv ***
`timescale 1ns/1ps
module eeos_sync3 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Asynchronous input and its filtered copy.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;

  // A bit changes only once the second and third stages agree, which drops one-cycle glitches.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
    end
  end

  // The first stage feeds only the second.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      out_r <= RST_VAL;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;

endmodule

// *** eeos_pad_model.sv ***
`timescale 1ns/1ps
// Pad loopback plus the supervisor's filtered view of the fault pins.
module eeos_pad_model #(
  parameter int unsigned WD_LIMIT = 40
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Pin drive, fault injection and mode.
  input wire eeos_pkg::eeos_pin_drv_t drv0,
  input wire eeos_pkg::eeos_pin_drv_t drv1,
  input wire logic stuck0,
  input wire logic single,
  // Separate signalling path from the safety software.
  input wire logic svc_pulse,
  input wire logic init_ok,
  // Pad levels, filtered verdict, watchdog and safe-state command.
  output logic rb0,
  output logic rb1,
  output logic sup_fault,
  output logic wd_exp,
  output logic sys_safe
);
  import eeos_pkg::*;
  logic raw_r;
  logic raw;
  logic lvl_r;
  logic lvl_chg;
  logic fed;
  logic armed_r;
  logic [7:0] wd_cnt_r;
  // Undriven pads fall to the fail level through the board pulls.
  assign rb0 = stuck0 ? 1'b1 : (drv0.oe_n ? PIN0_FAIL : drv0.o);
  assign rb1 = drv1.oe_n ? PIN1_FAIL : drv1.o;
  assign raw = single ? (rb0 == PIN0_FAIL) : (rb0 != rb1);
  // Two samples must agree, so a one-cycle glitch never flips the verdict.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      raw_r <= 1'b1;
      sup_fault <= 1'b1;
    end else begin
      raw_r <= raw;
      if (raw_r == raw) sup_fault <= raw_r;
    end
  end
  // A healthy pin toggle feeds the watchdog in dual mode; nothing is trusted while a fault shows.
  assign lvl_chg = !single && (rb0 != lvl_r);
  assign fed = (svc_pulse || lvl_chg) && !sup_fault;
  // The external reset output is not wired here, so reset cycling of the device starves the watchdog.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lvl_r <= PIN0_FAIL;
      armed_r <= 1'b0;
      wd_cnt_r <= '0;
      wd_exp <= 1'b0;
    end else begin
      lvl_r <= rb0;
      if (init_ok) armed_r <= 1'b1;
      if (fed) wd_cnt_r <= '0;
      else if (armed_r && !wd_exp) wd_cnt_r <= wd_cnt_r + 8'h01;
      if (armed_r && !fed && wd_cnt_r == 8'(WD_LIMIT - 1)) wd_exp <= 1'b1;
    end
  end
  // Either a reported fault or a starved watchdog commands the system safe state.
  assign sys_safe = sup_fault | wd_exp;
endmodule

// *** external_error_out_supervisor_test.sv ***
`timescale 1ns/1ps
module external_error_out_supervisor_test;
  import eeos_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic single_pin_mode = 1'b0;
  logic fault_active = 1'b0;
  eeos_sw_evt_t sw_evt = '0;
  logic low_voltage_detector = 1'b0;
  logic high_voltage_detector = 1'b0;
  logic stuck0 = 1'b0;
  logic rb0, rb1, sup_fault, ext_rst_n, init_ok, svc, run_st, pc_fail, safe_req;
  eeos_pin_drv_t p0, p1;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h00008C31;
  logic phase;
  logic wd_exp, sys_safe;
  localparam int unsigned WD_LIMIT = 40;

  // Free-running system clock.
  always #50 clk_sys = ~clk_sys;

  eeos_fault_out_ctrl dut (.clk_sys(clk_sys), .resetn(resetn), .single_pin_mode(single_pin_mode),
    .fault_active(fault_active), .sw_evt(sw_evt), .low_voltage_detector_err(low_voltage_detector),
    .high_voltage_detector_err(high_voltage_detector), .fault_out_0_i(rb0), .fault_out_1_i(rb1), .fault_out_0(p0),
    .fault_out_1(p1), .external_reset_out_n(ext_rst_n), .init_confirm(init_ok), .service_pulse(svc),
    .safety_run(run_st), .pin_check_fail(pc_fail), .safe_state_req(safe_req));

  eeos_pad_model #(.WD_LIMIT(WD_LIMIT)) pads (.clk_sys(clk_sys), .resetn(resetn), .drv0(p0), .drv1(p1),
    .stuck0(stuck0), .single(single_pin_mode), .svc_pulse(svc), .init_ok(init_ok), .rb0(rb0), .rb1(rb1),
    .sup_fault(sup_fault), .wd_exp(wd_exp), .sys_safe(sys_safe));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Expected pin level: fail pattern wins, single mode parks pin 0 high.
  function automatic logic exp_pin(input int idx, input logic sgl, input logic flt, input logic ph);
    if (flt) return (idx == 0) ? PIN0_FAIL : PIN1_FAIL;
    if (sgl && idx == 0) return 1'b1;
    return ph;
  endfunction

  task automatic chk(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic pulse(input int b);
    sw_evt[b] = 1'b1;
    cyc(1);
    sw_evt[b] = 1'b0;
    cyc(1);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      stop_test();
    end
  end

  // One full power-up and run; a stuck pad or a supply error ends it in the safe state.
  task automatic run(input int t, input logic sgl, input logic stk, input logic use_hvd);
    int k;
    logic f;
    logic s;
    stuck0 = stk;
    single_pin_mode = sgl;
    resetn = 1'b0;
    cyc(16);
    chk("reset_out", 1'b0, ext_rst_n);
    chk("pin0_reset", PIN0_FAIL, p0.o);
    resetn = 1'b1;
    k = 0;
    while (ext_rst_n !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    chk("reset_width", 1'b1, k == EXT_RST_CYC);
    pulse(3);
    pulse(2);
    pulse(1);
    chk("early_confirm", 1'b0, init_ok);
    chk("pin0_check", PIN0_FAIL, p0.o);
    chk("pin1_check", PIN1_FAIL, p1.o);
    cyc(25);
    chk("pin_check_fail", stk, pc_fail);
    if (stk) begin
      chk("check_safe", 1'b1, safe_req);
      chk("check_run", 1'b0, run_st);
      $display("test %0d done", t);
      return;
    end
    pulse(1);
    chk("confirm", 1'b1, init_ok);
    chk("run", 1'b1, run_st);
    chk("supervisor_ok", 1'b0, sup_fault);
    phase = PHASE_RST;
    for (k = 0; k < 40; k++) begin
      seed = xs(seed);
      s = seed[0];
      f = (seed[3:1] == 3'h0);
      sw_evt.sw_service = s;
      fault_active = f;
      cyc(1);
      if (s) phase = ~phase;
      chk("service_pulse", s, svc);
      chk("pin0", exp_pin(0, sgl, f, phase), p0.o);
      if (!sgl) chk("pin1", exp_pin(1, sgl, f, phase), p1.o);
      chk("pin1_release", sgl, p1.oe_n);
      chk("pin0_drive", 1'b0, p0.oe_n);
    end
    chk("wd_alive", 1'b0, wd_exp);
    sw_evt = '0;
    fault_active = 1'b1;
    cyc(4);
    chk("supervisor_fault", 1'b1, sup_fault);
    chk("supervisor_safe", 1'b1, sys_safe);
    fault_active = 1'b0;
    low_voltage_detector = 1'b1;
    cyc(1);
    low_voltage_detector = 1'b0;
    cyc(6);
    chk("glitch_run", 1'b1, run_st);
    if (use_hvd) high_voltage_detector = 1'b1;
    else low_voltage_detector = 1'b1;
    #1;
    chk("safe_now", 1'b1, safe_req);
    cyc(6);
    chk("volt_run", 1'b0, run_st);
    chk("volt_reset_out", 1'b0, ext_rst_n);
    low_voltage_detector = 1'b0;
    high_voltage_detector = 1'b0;
    cyc(6);
    chk("reset_out_back", 1'b1, ext_rst_n);
    chk("safe_held", 1'b1, safe_req);
    cyc(WD_LIMIT + 10);
    chk("wd_expired", 1'b1, wd_exp);
    chk("wd_safe", 1'b1, sys_safe);
    $display("test %0d done", t);
  endtask

  initial begin
    run(0, 1'b0, 1'b0, 1'b0);
    run(1, 1'b1, 1'b0, 1'b1);
    run(2, 1'b0, 1'b1, 1'b0);
    stop_test();
  end
endmodule
